/* File: bench/sstl_sync_src.sv */
// Purpose: Video sync source driving the horizontal and vertical pins
// Assumes: Shape inputs stay legal while run is high
// Notes:   Both pins are actively driven low while stopped
`default_nettype none

module sstl_sync_src (
    // Clock
    input  wire logic       hclk,
    // Waveform shape
    input  wire logic       run,
    input  wire logic [7:0] h_period,
    input  wire logic [7:0] h_high,
    input  wire logic [7:0] v_lines,
    // Sync pins
    output logic            hs,
    output logic            vs
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] pix_q = 8'h00;
    logic [7:0] line_q = 8'h00;

    // Vertical rises mid-line, so its clear never meets a count tick
    always @(posedge hclk) begin
        if (!run) begin
            pix_q  <= 8'h00;
            line_q <= 8'h00;
            hs     <= 1'b0;
            vs     <= 1'b0;
        end else begin
            pix_q <= (pix_q == h_period - 8'h01) ? 8'h00 : pix_q + 8'h01;
            if (pix_q == h_period - 8'h01) begin
                line_q <= (line_q == v_lines - 8'h01) ? 8'h00 : line_q + 8'h01;
            end
            hs <= pix_q < h_high;
            vs <= (line_q == 8'h00) && (pix_q >= (h_period >> 1));
        end
    end
endmodule

`default_nettype wire

/* File: bench/sstl_top_bench.sv */
// Purpose: Self-checking bench of the sync signal timer link
// Assumes: Zero wait state slave, sync source model on the pins
// Notes:   Expected figures follow from the programmed compares
`default_nettype none
`include "sstl_defines.svh"

module sstl_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] exp;
    } sstl_row_s;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, last_to, last_vs;
    logic        horizontal_sync_in, vertical_sync_in, decoded_pulse_out, clamp_wave_a, clamp_wave_b, timer_output;
    logic [7:0]  haddr, h_high;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, d;
    logic [31:0] cap [2];
    int          num_errors = 0, checks = 0, cycles = 0;
    int          w, v, t, off, off0;
    sstl_row_s   rows [10] = '{
        '{`SSTL_OFF_DEC_CTRL, 32'h0}, '{`SSTL_OFF_DEC_CMP, 32'hffff}, '{`SSTL_OFF_DIV_CTRL, 32'h0},
        '{`SSTL_OFF_DIV_CSR, 32'h0}, '{`SSTL_OFF_DIV_CMP, 32'hffff}, '{`SSTL_OFF_FRT_CTRL, 32'hffff0000},
        '{`SSTL_OFF_CAP_SEL, 32'h0}, '{`SSTL_OFF_STATUS, 32'h0}, '{`SSTL_OFF_FLAGS, 32'h0}, '{8'h40, 32'h0}};

    sstl_top sstl_top_inst (.*, .hsize(3'h2), .hready(hreadyout));

    sstl_sync_src sstl_sync_src_inst (
        .hclk(hclk), .run(run), .h_period(8'h3c), .h_high(h_high), .v_lines(8'h06),
        .hs(horizontal_sync_in), .vs(vertical_sync_in));

    initial hclk = 1'b0;
    always #4 hclk = ~hclk;

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test;
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Starts after an edge, ends at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= addr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= wdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdata = hrdata;
    endtask

    task automatic high_width(input logic sel, output int n);
        n = 0;
        while ((sel ? clamp_wave_b : clamp_wave_a) === 1'b1) @(posedge hclk);
        while ((sel ? clamp_wave_b : clamp_wave_a) !== 1'b1) @(posedge hclk);
        while ((sel ? clamp_wave_b : clamp_wave_a) === 1'b1) begin
            n++;
            @(posedge hclk);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic stop_test;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        run = 1'b0;
        h_high = 8'h14;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].addr, 32'h0, d);
            check_word(d, rows[i].exp);
        end
        bus(1'b1, 8'h40, 32'hffffffff, d);
        bus(1'b0, 8'h40, 32'h0, d);
        check_word(d, 32'h0);
        done("reset values");

        // Compare A 40, compare B 9
        bus(1'b1, `SSTL_OFF_DEC_CMP, 32'h0928, d);
        bus(1'b1, `SSTL_OFF_DEC_CTRL, {24'h0, 3'h0, `SSTL_CLR_EXT, `SSTL_CKS_INTERNAL}, d);
        run <= 1'b1;
        high_width(1'b0, w);
        check_word(w, 32'h29);
        high_width(1'b1, w);
        check_word(w, 32'h15);
        repeat (120) @(posedge hclk);
        check_word({31'h0, decoded_pulse_out}, 32'h1);
        h_high <= 8'h05;
        repeat (200) @(posedge hclk);
        check_word({31'h0, decoded_pulse_out}, 32'h0);
        done("decode and clamp");

        // Compare A 3 toggles once per 6-line frame; a match B at 1 must leave the output alone
        bus(1'b1, `SSTL_OFF_DIV_CMP, 32'h0103, d);
        bus(1'b1, `SSTL_OFF_DIV_CSR, 32'h3, d);
        bus(1'b1, `SSTL_OFF_DIV_CTRL, {24'h0, 3'h0, `SSTL_CLR_EXT, `SSTL_CKS_EXT_RISE}, d);
        v = 0;
        t = 0;
        off = 0;
        off0 = 0;
        while (v < 5) begin
            last_to = timer_output;
            last_vs = vertical_sync_in;
            @(posedge hclk);
            off++;
            if (vertical_sync_in && !last_vs) begin
                v++;
                off = 0;
            end
            if (timer_output !== last_to && v > 0) begin
                t++;
                if (t == 1) off0 = off;
                check_word(off, off0);
            end
        end
        check_word(t, 32'h4);
        check_word(32'(off0 >= 32'hd2 && off0 <= 32'hdc), 32'h1);
        done("divider");

        // A low compare with clearing off must not disturb the count
        bus(1'b1, `SSTL_OFF_FRT_CTRL, 32'h00100200, d);
        for (int s = 1; s >= 0; s--) begin
            bus(1'b1, `SSTL_OFF_CAP_SEL, s, d);
            for (int k = 0; k < 2; k++) begin
                if (s == 1) @(posedge vertical_sync_in);
                else @(posedge timer_output);
                repeat (20) @(posedge hclk);
                bus(1'b0, `SSTL_OFF_ICR, 32'h0, cap[k]);
            end
            bus(1'b0, `SSTL_OFF_FRC, 32'h0, d);
            check_word((cap[1] - cap[0]) & 32'hffff, (s == 1) ? 32'hb4 : 32'h168);
            check_word(32'(((d - cap[1]) & 32'hffff) < 32'h18), 32'h1);
        end
        done("capture");

        run <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        check_word({27'h0, hreadyout, decoded_pulse_out, clamp_wave_a, clamp_wave_b, timer_output}, 32'h10);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `SSTL_OFF_DIV_CSR, 32'h0, d);
        check_word(d, 32'h0);
        done("second reset");
        stop_test;
    end
endmodule

`default_nettype wire

/* File: bench/sstl_top_sva.sv */
// Purpose: Port checks of the sync signal timer link
// Assumes: Sync pins held low across a reset
// Notes:   Exact counts are left to the bench
`default_nettype none

module sstl_top_sva (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic horizontal_sync_in,
    input wire logic decoded_pulse_out,
    input wire logic clamp_wave_a,
    input wire logic clamp_wave_b,
    input wire logic timer_output
);
    logic       hs_q;
    logic [3:0] rise_age_q;
    logic [3:0] fall_age_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Reset like the synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_q       <= 1'b0;
            rise_age_q <= 4'hf;
            fall_age_q <= 4'hf;
        end else begin
            hs_q       <= horizontal_sync_in;
            rise_age_q <= (horizontal_sync_in && !hs_q) ? 4'h0 : rise_age_q + 4'(rise_age_q != 4'hf);
            fall_age_q <= (!horizontal_sync_in && hs_q) ? 4'h0 : fall_age_q + 4'(fall_age_q != 4'hf);
        end
    end

    ready_high_a: assert property (hreadyout) else $error("hreadyout dropped");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    clamp_a_set_a: assert property ($rose(horizontal_sync_in) |-> ##[2:6] clamp_wave_a)
        else $error("clamp a missed a horizontal rise");
    clamp_b_set_a: assert property ($fell(horizontal_sync_in) |-> ##[2:6] clamp_wave_b)
        else $error("clamp b missed a horizontal fall");
    clamp_a_cause_a: assert property ($rose(clamp_wave_a) |-> rise_age_q <= 4'h6)
        else $error("clamp a rose without a horizontal rise");
    clamp_b_cause_a: assert property ($rose(clamp_wave_b) |-> fall_age_q <= 4'h6)
        else $error("clamp b rose without a horizontal fall");
    clamps_fall_a: assert property ($fell(clamp_wave_a) |-> !clamp_wave_b || !$past(clamp_wave_b))
        else $error("clamps did not fall together");
    div_toggle_a: assert property ($changed(timer_output) |-> rise_age_q <= 4'h8)
        else $error("divider output moved without a horizontal rise");
    pulse_latch_a: assert property ($changed(decoded_pulse_out) |->
        decoded_pulse_out == $past(horizontal_sync_in, 3) || decoded_pulse_out == $past(horizontal_sync_in, 4))
        else $error("decoded pulse differs from latched level");

    cover property ($fell(clamp_wave_a));
    cover property ($changed(timer_output));
    cover property ($rose(decoded_pulse_out));
endmodule

bind sstl_top sstl_top_sva sstl_top_sva_inst (.*);

`default_nettype wire

/* File: design/sstl_defines.svh */
// Purpose: Named constants of the sync signal timer link block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes:   Offsets are byte addresses
`ifndef SSTL_DEFINES_SVH
`define SSTL_DEFINES_SVH

// Register byte offsets
`define SSTL_OFF_DEC_CTRL   8'h00
`define SSTL_OFF_DEC_CMP    8'h04
`define SSTL_OFF_DIV_CTRL   8'h08
`define SSTL_OFF_DIV_CSR    8'h0c
`define SSTL_OFF_DIV_CMP    8'h10
`define SSTL_OFF_FRT_CTRL   8'h14
`define SSTL_OFF_STATUS     8'h18
`define SSTL_OFF_FRC        8'h1c
`define SSTL_OFF_ICR        8'h20
`define SSTL_OFF_CAP_SEL    8'h24
`define SSTL_OFF_FLAGS      8'h28

// Reset values
`define SSTL_RST_TCR        8'h00
`define SSTL_RST_CMP        8'hff
`define SSTL_RST_OS         4'h0
`define SSTL_RST_FRT_CMP    16'hffff

// Timer control field positions
`define SSTL_TCR_MSB        7
`define SSTL_CSR_PULSE_MODE_ENABLE       4
`define SSTL_CSR_OS_MSB     3
`define SSTL_CMP_A_MSB      7
`define SSTL_CMP_B_LSB      8
`define SSTL_CMP_B_MSB      15
`define SSTL_FRT_CKS_MSB    1
`define SSTL_FRT_COUNTER_CLEAR_CONTROL       8
`define SSTL_FRT_CAPTURE_EDGE_SELECT       9
`define SSTL_FRT_CMP_LSB    16
`define SSTL_FRT_CMP_MSB    31

// Clear select codes
`define SSTL_CLR_NONE       2'h0
`define SSTL_CLR_MATCH_A    2'h1
`define SSTL_CLR_MATCH_B    2'h2
`define SSTL_CLR_EXT        2'h3

// Clock select codes of the 8-bit timers
`define SSTL_CKS_INTERNAL   3'h1
`define SSTL_CKS_EXT_RISE   3'h5
`define SSTL_CKS_EXT_FALL   3'h6
`define SSTL_CKS_EXT_BOTH   3'h7

// Free-running timer prescale
`define SSTL_FRT_DIV2       2'h0
`define SSTL_FRT_DIV8       2'h1
`define SSTL_FRT_DIV32      2'h2
`define SSTL_PSC_M2         5'h01
`define SSTL_PSC_M8         5'h07
`define SSTL_PSC_M32        5'h1f

// Output actions per compare match
`define SSTL_OUT_KEEP       2'h0
`define SSTL_OUT_CLEAR      2'h1
`define SSTL_OUT_SET        2'h2
`define SSTL_OUT_TOGGLE     2'h3

`endif

/* File: design/sstl_pkg.sv */
// Purpose: Types shared by the sync signal timer link block
// Assumes: Constants live in sstl_defines.svh
// Notes:   Control structs mirror the register bit layout
`default_nettype none

package sstl_pkg;

    // 8-bit timer control, bit 7 down to bit 0
    typedef struct packed {
        logic       match_b_irq_enable;
        logic       match_a_irq_enable;
        logic       overflow_irq_enable;
        logic [1:0] clear_select;
        logic [2:0] clock_select;
    } sstl_tcr_s;

    // Synchronised input with its edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } sstl_edge_s;

    // Compare pair of one 8-bit timer
    typedef struct packed {
        logic [7:0] cmp_b;
        logic [7:0] cmp_a;
    } sstl_cmp_s;

endpackage

`default_nettype wire

/* File: design/sstl_sync.sv */
// Purpose: Two-flop synchroniser with rise and fall detection
// Assumes: Input is asynchronous to hclk
// Notes:   Edges lag the pin by two to three clocks
`default_nettype none

module sstl_sync (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Pin and result
    input  wire logic             pin_in,
    output sstl_pkg::sstl_edge_s  sync_out
);
    import sstl_pkg::*;

    logic meta_q;
    logic sync_q;
    logic hist_q;

    // Only sync_q reads meta_q
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            hist_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            hist_q <= sync_q;
        end
    end

    assign sync_out.level = sync_q;
    assign sync_out.rise  = sync_q & ~hist_q;
    assign sync_out.fall  = ~sync_q & hist_q;

endmodule

`default_nettype wire

/* File: design/sstl_timer8.sv */
// Purpose: 8-bit timer with two compares, clear select and output
// Assumes: Count tick and external clear are one-cycle pulses
// Notes:   A match fires on the tick that ends count value = compare
`default_nettype none
`include "sstl_defines.svh"

module sstl_timer8 (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // Control
    input  wire logic                count_tick,
    input  wire logic                ext_clear,
    input  wire sstl_pkg::sstl_tcr_s tcr,
    input  wire logic [3:0]          output_select,
    input  wire sstl_pkg::sstl_cmp_s cmp,
    // Results
    output logic [7:0]               timer_count,
    output logic                     match_a_event,
    output logic                     match_b_event,
    output logic                     overflow_event,
    output logic                     timer_output
);
    import sstl_pkg::*;

    logic [7:0] cnt_q;
    logic       tmo_q;
    logic       clear_now;

    // Fires value+1 ticks after clear (R3)
    assign match_a_event  = count_tick && (cnt_q == cmp.cmp_a);
    assign match_b_event  = count_tick && (cnt_q == cmp.cmp_b); // R3
    assign overflow_event = count_tick && (cnt_q == 8'hff);

    always_comb begin
        unique case (tcr.clear_select)
            `SSTL_CLR_MATCH_A: clear_now = match_a_event;
            `SSTL_CLR_MATCH_B: clear_now = match_b_event;
            `SSTL_CLR_EXT:     clear_now = ext_clear; // R1 R7
            default:           clear_now = 1'b0;
        endcase
    end

    // External clear beats a coincident tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
        end else if (clear_now) begin
            cnt_q <= 8'h00;
        end else if (count_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // A match A action other than keep wins over match B when both hit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_q <= 1'b0;
        end else if (match_a_event && output_select[1:0] != `SSTL_OUT_KEEP) begin
            tmo_q <= (output_select[1:0] == `SSTL_OUT_TOGGLE) ? ~tmo_q : output_select[1]; // R9
        end else if (match_b_event && output_select[3:2] != `SSTL_OUT_KEEP) begin
            tmo_q <= (output_select[3:2] == `SSTL_OUT_TOGGLE) ? ~tmo_q : output_select[3];
        end
    end

    assign timer_count  = cnt_q;
    assign timer_output = tmo_q;

endmodule

`default_nettype wire

/* File: design/sstl_top.sv */
// Purpose: Sync signal timer link with AHB-Lite register slave
// Assumes: Sync pins asynchronous to hclk; single word transfers
// Notes:   Zero wait state slave; interrupt enables are stored only
//
// Operation
// (R1) Decode timer counts every clock, cleared by horizontal rising edge.
// (R2) Decode timer match and overflow interrupt enables reset to zero.
// (R3) Compare B threshold equals value plus one clock periods.
// (R4) Decoder latches horizontal level at first match B after rise.
// (R5) Clamp A rises with horizontal rise, clamp B with its fall.
// (R6) Both clamps fall on decode timer compare A match.
// (R7) Divider timer counts horizontal rises, cleared by vertical rising edge.
// (R8) Vertical clear aligns the divided waveform with vertical sync.
// (R9) Divider output ignores match B, toggles on match A.
// (R10) Free-running counter runs at half clock with clock select 00.
// (R11) Edge select 1 captures counter on rising capture input.
// (R12) Clear control 0 keeps the free-running counter never cleared.
// (R13) Software derives periods from differences of successive captures.
// (R14) Sync inputs are synchronised so each edge gives one event.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
`include "sstl_defines.svh"

module sstl_top (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Sync inputs
    input  wire logic        horizontal_sync_in,
    input  wire logic        vertical_sync_in,
    // Waveform outputs
    output logic             decoded_pulse_out,
    output logic             clamp_wave_a,
    output logic             clamp_wave_b,
    output logic             timer_output
);
    import sstl_pkg::*;

    sstl_edge_s hs;
    sstl_edge_s vs;

    // Software state
    sstl_tcr_s  dec_tcr_q;
    sstl_tcr_s  div_tcr_q;
    sstl_cmp_s  dec_cmp_q;
    sstl_cmp_s  div_cmp_q;
    logic [3:0]  div_os_q;
    logic        div_pulse_mode_enable_q;
    logic [1:0]  frt_cks_q;
    logic        frt_counter_clear_control_q;
    logic        frt_capture_edge_select_q;
    logic [15:0] frt_cmp_q;
    logic        cap_sel_q;

    // Block state
    logic [15:0] frc_q;
    logic [15:0] icr_q;
    logic [4:0]  psc_q;
    logic        cap_prev_q;
    logic        pdc_q;
    logic        armed_q;
    logic        cl_a_q;
    logic        cl_b_q;
    logic [5:0]  flags_q;

    // Bus state
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;

    logic [7:0]  dec_count;
    logic [7:0]  div_count;
    logic        dec_ma;
    logic        dec_mb;
    logic        dec_ovf;
    logic        div_ma;
    logic        div_mb;
    logic        div_ovf;
    logic        div_tmo;
    logic        frt_tick;
    logic        cap_src;
    logic        cap_event;
    logic        addr_phase;

    // Tick from a timer clock select
    function automatic logic sel_tick(input logic [2:0] sel,
                                      input logic       rise,
                                      input logic       fall);
        unique case (sel)
            `SSTL_CKS_INTERNAL: sel_tick = 1'b1;
            `SSTL_CKS_EXT_RISE: sel_tick = rise;
            `SSTL_CKS_EXT_FALL: sel_tick = fall;
            `SSTL_CKS_EXT_BOTH: sel_tick = rise | fall;
            default:            sel_tick = 1'b0;
        endcase
    endfunction

    // Pins are asynchronous to hclk
    sstl_sync u_hsync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   (horizontal_sync_in),
        .sync_out (hs)
    ); // R14

    sstl_sync u_vsync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   (vertical_sync_in),
        .sync_out (vs)
    ); // R14

    // Decode timer for pulse decoding and clamps
    sstl_timer8 u_decode_timer (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .count_tick     (sel_tick(dec_tcr_q.clock_select, hs.rise, hs.fall)), // R1
        .ext_clear      (hs.rise),
        .tcr            (dec_tcr_q),
        .output_select  (`SSTL_RST_OS),
        .cmp            (dec_cmp_q),
        .timer_count    (dec_count),
        .match_a_event  (dec_ma),
        .match_b_event  (dec_mb),
        .overflow_event (dec_ovf),
        .timer_output   ()
    );

    // Divider timer; vertical clear keeps its output phase locked to frames
    sstl_timer8 u_divider_timer (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .count_tick     (sel_tick(div_tcr_q.clock_select, hs.rise, hs.fall)), // R7
        .ext_clear      (vs.rise), // R8
        .tcr            (div_tcr_q),
        .output_select  (div_os_q), // R9
        .cmp            (div_cmp_q),
        .timer_count    (div_count),
        .match_a_event  (div_ma),
        .match_b_event  (div_mb),
        .overflow_event (div_ovf),
        .timer_output   (div_tmo)
    );

    // Pulse width decoder: one sample per horizontal period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 1'b0;
            pdc_q   <= 1'b0;
        end else begin
            if (hs.rise) begin
                armed_q <= 1'b1;
            end else if (dec_mb && armed_q) begin
                armed_q <= 1'b0;
            end
            if (dec_mb && armed_q) begin
                pdc_q <= hs.level; // R4
            end
        end
    end

    // Clamp waveforms; the setting edge (rise for A, fall for B) beats a coincident match A
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cl_a_q <= 1'b0;
            cl_b_q <= 1'b0;
        end else begin
            if (hs.rise) begin
                cl_a_q <= 1'b1; // R5
            end else if (dec_ma) begin
                cl_a_q <= 1'b0; // R6
            end
            if (hs.fall) begin
                cl_b_q <= 1'b1; // R5
            end else if (dec_ma) begin
                cl_b_q <= 1'b0; // R6
            end
        end
    end

    // Free-running timer prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_q <= 5'h00;
        end else begin
            psc_q <= psc_q + 5'h01;
        end
    end

    always_comb begin
        unique case (frt_cks_q)
            `SSTL_FRT_DIV2:  frt_tick = (psc_q[0] == `SSTL_PSC_M2);  // R10
            `SSTL_FRT_DIV8:  frt_tick = ((psc_q & `SSTL_PSC_M8) == `SSTL_PSC_M8);
            `SSTL_FRT_DIV32: frt_tick = (psc_q == `SSTL_PSC_M32);
            default:         frt_tick = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frc_q <= 16'h0000;
        end else if (frt_counter_clear_control_q && frt_tick && frc_q == frt_cmp_q) begin
            frc_q <= 16'h0000; // R12
        end else if (frt_tick) begin
            frc_q <= frc_q + 16'h0001; // R10
        end
    end

    // Capture from divided waveform or vertical input
    assign cap_src   = cap_sel_q ? vs.level : div_tmo;
    assign cap_event = frt_capture_edge_select_q ? (cap_src & ~cap_prev_q) : (~cap_src & cap_prev_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_prev_q <= 1'b0;
            icr_q      <= 16'h0000;
        end else begin
            cap_prev_q <= cap_src;
            if (cap_event) begin
                icr_q <= frc_q; // R11 R13
            end
        end
    end

    // AHB-Lite address phase
    assign addr_phase = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr;
        end
    end

    wire wr_ctl = wr_pend_q;

    // Control registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_tcr_q  <= sstl_tcr_s'(`SSTL_RST_TCR); // R2
            div_tcr_q  <= sstl_tcr_s'(`SSTL_RST_TCR);
            dec_cmp_q  <= {`SSTL_RST_CMP, `SSTL_RST_CMP};
            div_cmp_q  <= {`SSTL_RST_CMP, `SSTL_RST_CMP};
            div_os_q   <= `SSTL_RST_OS;
            div_pulse_mode_enable_q <= 1'b0;
            frt_cks_q  <= `SSTL_FRT_DIV2;
            frt_counter_clear_control_q <= 1'b0;
            frt_capture_edge_select_q <= 1'b0;
            frt_cmp_q  <= `SSTL_RST_FRT_CMP;
            cap_sel_q  <= 1'b0;
        end else if (wr_ctl) begin
            unique case (wr_addr_q)
                `SSTL_OFF_DEC_CTRL: dec_tcr_q <= sstl_tcr_s'(hwdata[`SSTL_TCR_MSB:0]);
                `SSTL_OFF_DEC_CMP:  dec_cmp_q <= hwdata[`SSTL_CMP_B_MSB:0];
                `SSTL_OFF_DIV_CTRL: div_tcr_q <= sstl_tcr_s'(hwdata[`SSTL_TCR_MSB:0]);
                `SSTL_OFF_DIV_CSR: begin
                    div_pulse_mode_enable_q <= hwdata[`SSTL_CSR_PULSE_MODE_ENABLE];
                    div_os_q   <= hwdata[`SSTL_CSR_OS_MSB:0];
                end
                `SSTL_OFF_DIV_CMP:  div_cmp_q <= hwdata[`SSTL_CMP_B_MSB:0];
                `SSTL_OFF_FRT_CTRL: begin
                    frt_cks_q  <= hwdata[`SSTL_FRT_CKS_MSB:0];
                    frt_counter_clear_control_q <= hwdata[`SSTL_FRT_COUNTER_CLEAR_CONTROL];
                    frt_capture_edge_select_q <= hwdata[`SSTL_FRT_CAPTURE_EDGE_SELECT];
                    frt_cmp_q  <= hwdata[`SSTL_FRT_CMP_MSB:`SSTL_FRT_CMP_LSB];
                end
                `SSTL_OFF_CAP_SEL:  cap_sel_q <= hwdata[0];
                default: ;
            endcase
        end
    end

    // Sticky event flags; write 0 clears, a new event wins
    wire [5:0] flag_set = {cap_event, div_ovf, div_ma, dec_ovf, dec_mb, dec_ma};
    wire       flag_wr  = wr_ctl && wr_addr_q == `SSTL_OFF_FLAGS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= flag_set | (flag_wr ? (flags_q & hwdata[5:0]) : flags_q);
        end
    end

    // Read data taken in the address phase
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        unique case (a)
            `SSTL_OFF_DEC_CTRL: rd_mux = {24'h000000, dec_tcr_q};
            `SSTL_OFF_DEC_CMP:  rd_mux = {16'h0000, dec_cmp_q};
            `SSTL_OFF_DIV_CTRL: rd_mux = {24'h000000, div_tcr_q};
            `SSTL_OFF_DIV_CSR:  rd_mux = {27'h0000000, div_pulse_mode_enable_q, div_os_q};
            `SSTL_OFF_DIV_CMP:  rd_mux = {16'h0000, div_cmp_q};
            `SSTL_OFF_FRT_CTRL: rd_mux = {frt_cmp_q, 6'h00, frt_capture_edge_select_q, frt_counter_clear_control_q, 6'h00, frt_cks_q};
            `SSTL_OFF_STATUS:   rd_mux = {12'h000, div_tmo, cl_b_q, cl_a_q, pdc_q, div_count, dec_count};
            `SSTL_OFF_FRC:      rd_mux = {16'h0000, frc_q};
            `SSTL_OFF_ICR:      rd_mux = {16'h0000, icr_q};
            `SSTL_OFF_CAP_SEL:  rd_mux = {31'h00000000, cap_sel_q};
            `SSTL_OFF_FLAGS:    rd_mux = {26'h0000000, flags_q};
            default:            rd_mux = 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            rdata_q <= rd_mux(haddr);
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    assign decoded_pulse_out = pdc_q;
    assign clamp_wave_a      = cl_a_q;
    assign clamp_wave_b      = cl_b_q;
    assign timer_output      = div_tmo;

endmodule

`default_nettype wire
